// >>> hdl/eoc_pkg.sv
// constants, register map and types of the external oscillator control block
package eoc_pkg;

	// register indices; byte address on the bus is four times the index
	localparam logic [9:0] EOC_IDX_FINE_TRIM   = 10'h0B0;
	localparam logic [9:0] EOC_IDX_EXT_OSC     = 10'h0B1;
	localparam logic [9:0] EOC_IDX_CLK_SEL     = 10'h0B4;
	localparam logic [9:0] EOC_IDX_IRQ_STATUS  = 10'h0B5;
	localparam logic [9:0] EOC_IDX_IRQ_MASK    = 10'h0B6;

	// fine trim register
	localparam int         EOC_TRIM_W          = 6;
	localparam logic [5:0] EOC_TRIM_MAX        = 6'h27;

	// external oscillator control register fields
	localparam int         EOC_XC_VALID_BIT    = 7;
	localparam int         EOC_XC_MODE_LSB     = 4;
	localparam int         EOC_XC_RSVD_BIT     = 3;
	localparam int         EOC_XC_FREQ_LSB     = 0;
	localparam logic [2:0] EOC_MODE_RESET      = 3'h0;
	localparam logic [2:0] EOC_FREQ_RESET      = 3'h0;

	// external mode encodings
	localparam logic [2:0] EOC_MODE_CMOS       = 3'h2;
	localparam logic [2:0] EOC_MODE_CMOS_DIV2  = 3'h3;
	localparam logic [2:0] EOC_MODE_RC         = 3'h4;
	localparam logic [2:0] EOC_MODE_CAP        = 3'h5;
	localparam logic [2:0] EOC_MODE_XTAL       = 3'h6;
	localparam logic [2:0] EOC_MODE_XTAL_DIV2  = 3'h7;

	// clock select register
	localparam int         EOC_CS_SEL_BIT      = 0;
	localparam logic       EOC_CS_RESET        = 1'b0;

	// interrupt status and mask layout
	localparam int         EOC_IRQ_W           = 4;
	localparam int         EOC_EV_XTAL_VALID   = 0;
	localparam int         EOC_EV_XTAL_LOST    = 1;
	localparam int         EOC_EV_TRIM_RANGE   = 2;
	localparam int         EOC_EV_SEL_REFUSED  = 3;
	localparam logic [3:0] EOC_IRQ_RESET       = 4'h0;

	// external clock division toward timers and counter array
	localparam logic [3:0] EOC_DIV_LAST        = 4'h7;
	localparam logic [3:0] EOC_DIV_LAST_HALF   = 4'hF;

	// crystal start-up tracker, gray coded along off, wait, valid
	typedef enum logic [1:0] {
		EOC_XST_OFF   = 2'b00,
		EOC_XST_WAIT  = 2'b01,
		EOC_XST_VALID = 2'b11
	} eoc_xst_type;

endpackage

// >>> hdl/eoc_ext_osc_ctrl.sv
// external oscillator control with fine trim and clock select registers
//
// Contract
// - fine trim upper two bits read zero
// - fine trim loads factory value at reset
// - mode field selects off, cmos, rc, cap, crystal
// - bit 7 reads crystal valid, read only
// - bit 3 reserved, reads zero, write zero
// - external clock divided by eight for timers
// - divided clock synchronised, half cycle jitter
// - crystal claims both pins, others output pin
// - clock select: 0 internal, 1 external
//
// Local design decision: the Wishbone register port.
`timescale 1ns/10ps
`default_nettype none

module eoc_ext_osc_ctrl (
	input  wire logic                          I_CLOCK,
	input  wire logic                          I_SYS_RST,
	input  wire logic                          I_WB_CYC,
	input  wire logic                          I_WB_STB,
	input  wire logic                          I_WB_WE,
	input  wire logic [11:0]                   I_WB_ADR,
	input  wire logic [31:0]                   I_WB_DAT,
	input  wire logic [3:0]                    I_WB_SEL,
	output var  logic [31:0]                   O_WB_DAT,
	output var  logic                          O_WB_ACK,
	input  wire logic [eoc_pkg::EOC_TRIM_W-1:0] I_FACTORY_TRIM,
	input  wire logic                          I_EXT_OSC_CLK,
	input  wire logic                          I_XTAL_AMP_OK,
	output var  logic [eoc_pkg::EOC_TRIM_W-1:0] O_FINE_TRIM,
	output var  logic [2:0]                    O_EXT_OSC_MODE_SEL,
	output var  logic [2:0]                    O_EXT_OSC_FREQ_CTRL,
	output var  logic                          O_OSC_ENABLE,
	output var  logic                          O_OSC_CMOS,
	output var  logic                          O_OSC_RC,
	output var  logic                          O_OSC_CAP,
	output var  logic                          O_OSC_XTAL,
	output var  logic                          O_OSC_HALF,
	output var  logic                          O_OSC_IN_PIN_CLAIM,
	output var  logic                          O_OSC_OUT_PIN_CLAIM,
	output var  logic                          O_CRYSTAL_VALID_FLAG,
	output var  logic                          O_SYSCLK_SOURCE_SEL,
	output var  logic                          O_EXT_DIV8_TICK,
	output var  logic                          O_IRQ
);
	import eoc_pkg::*;

	// bus request decode
	logic                  req;
	logic                  wr_fire;
	logic                  lane0;
	logic [9:0]            idx;
	logic                  hit_trim;
	logic                  hit_xc;
	logic                  hit_cs;
	logic                  hit_sts;
	logic                  hit_msk;

	// register state
	logic                  ack_q;
	logic [31:0]           rd_q;
	logic [EOC_TRIM_W-1:0] trim_q;
	logic [2:0]            mode_q;
	logic [2:0]            freq_q;
	logic                  sel_q;
	logic [EOC_IRQ_W-1:0]  sts_q;
	logic [EOC_IRQ_W-1:0]  msk_q;
	logic [EOC_IRQ_W-1:0]  ev;
	logic                  irq_q;

	// synchronisers and clock division
	logic [2:0]            clk_sync_q;
	logic [2:0]            amp_sync_q;
	logic                  ext_rise;
	logic                  amp_ok;
	logic [3:0]            div_cnt_q;
	logic [3:0]            div_last;
	logic                  tick_q;

	// crystal tracker
	eoc_xst_type           xst_q;
	eoc_xst_type           xst_d;
	logic                  xtal_mode;
	logic                  osc_on;
	logic                  ext_ready;
	logic                  sel_req;
	logic                  valid_q;

	// decoded mode outputs
	logic                  en_q;
	logic                  cmos_q;
	logic                  rc_q;
	logic                  cap_q;
	logic                  xtal_q;
	logic                  half_q;
	logic                  pin_in_q;
	logic                  pin_out_q;

	assign req      = I_WB_CYC & I_WB_STB;
	// writes land on the edge where the master samples ack
	assign wr_fire  = req & I_WB_WE & ack_q;
	assign lane0    = I_WB_SEL[0];
	assign idx      = I_WB_ADR[11:2];
	assign hit_trim = (idx == EOC_IDX_FINE_TRIM);
	assign hit_xc   = (idx == EOC_IDX_EXT_OSC);
	assign hit_cs   = (idx == EOC_IDX_CLK_SEL);
	assign hit_sts  = (idx == EOC_IDX_IRQ_STATUS);
	assign hit_msk  = (idx == EOC_IDX_IRQ_MASK);

	assign xtal_mode = mode_q[2] & mode_q[1];
	assign osc_on    = (mode_q[2:1] != 2'b00);
	// an enabled non-crystal source counts as settled at once, a crystal only once it reads valid
	assign ext_ready = osc_on & (~xtal_mode | valid_q);
	assign sel_req   = I_WB_DAT[EOC_CS_SEL_BIT];

	// single-cycle ack; unmapped indices answer with zero data
	always_ff @(posedge I_CLOCK) begin
		if (I_SYS_RST) begin
			ack_q <= 1'b0;
		end else begin
			ack_q <= req & ~ack_q;
		end
	end

	always_ff @(posedge I_CLOCK) begin
		if (I_SYS_RST) begin
			rd_q <= 32'h0000_0000;
		end else if (req & ~ack_q) begin
			rd_q <= 32'h0000_0000;
			if (hit_trim) begin
				rd_q[EOC_TRIM_W-1:0] <= trim_q;
			end
			if (hit_xc) begin
				rd_q[EOC_XC_VALID_BIT]             <= valid_q;
				rd_q[EOC_XC_MODE_LSB+:3]           <= mode_q;
				rd_q[EOC_XC_RSVD_BIT]              <= 1'b0;
				rd_q[EOC_XC_FREQ_LSB+:3]           <= freq_q;
			end
			if (hit_cs) begin
				rd_q[EOC_CS_SEL_BIT] <= sel_q;
			end
			if (hit_sts) begin
				rd_q[EOC_IRQ_W-1:0] <= sts_q;
			end
			if (hit_msk) begin
				rd_q[EOC_IRQ_W-1:0] <= msk_q;
			end
		end
	end

	// the trim loads the factory calibration, never a fixed constant
	always_ff @(posedge I_CLOCK) begin
		if (I_SYS_RST) begin
			trim_q <= I_FACTORY_TRIM;
		end else if (wr_fire & lane0 & hit_trim) begin
			trim_q <= I_WB_DAT[EOC_TRIM_W-1:0];
		end
	end

	// reserved bit 3 and valid bit 7 are not stored; frequency code is
	// kept as written, its meaning depends on the mode
	always_ff @(posedge I_CLOCK) begin
		if (I_SYS_RST) begin
			mode_q <= EOC_MODE_RESET;
			freq_q <= EOC_FREQ_RESET;
		end else if (wr_fire & lane0 & hit_xc) begin
			mode_q <= I_WB_DAT[EOC_XC_MODE_LSB+:3];
			freq_q <= I_WB_DAT[EOC_XC_FREQ_LSB+:3];
		end
	end

	// a switch to an unsettled external source is refused, and the select
	// falls back to internal when the oscillator is turned off, not when a crystal loses valid
	always_ff @(posedge I_CLOCK) begin
		if (I_SYS_RST) begin
			sel_q <= EOC_CS_RESET;
		end else if (wr_fire & lane0 & hit_cs) begin
			if (~sel_req | ext_ready) begin
				sel_q <= sel_req;
			end
		end else if (sel_q & ~osc_on) begin
			sel_q <= 1'b0;
		end
	end

	// three-stage synchronisers; only stages two and three are compared
	always_ff @(posedge I_CLOCK) begin
		if (I_SYS_RST) begin
			clk_sync_q <= 3'h0;
			amp_sync_q <= 3'h0;
		end else begin
			clk_sync_q <= {clk_sync_q[1:0], I_EXT_OSC_CLK};
			amp_sync_q <= {amp_sync_q[1:0], I_XTAL_AMP_OK};
		end
	end

	assign ext_rise = clk_sync_q[1] & ~clk_sync_q[2];
	assign amp_ok   = amp_sync_q[1] & amp_sync_q[2];
	// the divide-by-two stage doubles the edge count per tick
	assign div_last = half_q ? EOC_DIV_LAST_HALF : EOC_DIV_LAST;

	// edges are counted in the system domain, so the external clock
	// must run at less than half the system clock
	always_ff @(posedge I_CLOCK) begin
		if (I_SYS_RST) begin
			div_cnt_q <= 4'h0;
			tick_q    <= 1'b0;
		end else if (~en_q) begin
			div_cnt_q <= 4'h0;
			tick_q    <= 1'b0;
		end else begin
			tick_q <= 1'b0;
			if (ext_rise) begin
				if (div_cnt_q == div_last) begin
					div_cnt_q <= 4'h0;
					tick_q    <= 1'b1;
				end else begin
					div_cnt_q <= div_cnt_q + 4'h1;
				end
			end
		end
	end

	always_comb begin
		xst_d = xst_q;
		unique case (xst_q)
			EOC_XST_OFF: begin
				if (xtal_mode) begin
					xst_d = EOC_XST_WAIT;
				end
			end
			EOC_XST_WAIT: begin
				if (~xtal_mode) begin
					xst_d = EOC_XST_OFF;
				end else if (amp_ok) begin
					xst_d = EOC_XST_VALID;
				end
			end
			EOC_XST_VALID: begin
				if (~xtal_mode) begin
					xst_d = EOC_XST_OFF;
				end else if (~amp_ok) begin
					xst_d = EOC_XST_WAIT;
				end
			end
			default: begin
				xst_d = EOC_XST_OFF;
			end
		endcase
	end

	always_ff @(posedge I_CLOCK) begin
		if (I_SYS_RST) begin
			xst_q   <= EOC_XST_OFF;
			valid_q <= 1'b0;
		end else begin
			xst_q   <= xst_d;
			valid_q <= (xst_d == EOC_XST_VALID);
		end
	end

	// events: valid rise, valid loss, out-of-range trim, refused switch
	always_comb begin
		ev = '0;
		ev[EOC_EV_XTAL_VALID]  = (xst_d == EOC_XST_VALID) & ~valid_q;
		ev[EOC_EV_XTAL_LOST]   = (xst_q == EOC_XST_VALID) &
			(xst_d == EOC_XST_WAIT);
		ev[EOC_EV_TRIM_RANGE]  = wr_fire & lane0 & hit_trim &
			(I_WB_DAT[EOC_TRIM_W-1:0] > EOC_TRIM_MAX);
		ev[EOC_EV_SEL_REFUSED] = wr_fire & lane0 & hit_cs & sel_req &
			~ext_ready;
	end

	// write one to clear; a new event in the same cycle wins
	always_ff @(posedge I_CLOCK) begin
		if (I_SYS_RST) begin
			sts_q <= EOC_IRQ_RESET;
		end else if (wr_fire & lane0 & hit_sts) begin
			sts_q <= (sts_q & ~I_WB_DAT[EOC_IRQ_W-1:0]) | ev;
		end else begin
			sts_q <= sts_q | ev;
		end
	end

	always_ff @(posedge I_CLOCK) begin
		if (I_SYS_RST) begin
			msk_q <= EOC_IRQ_RESET;
		end else if (wr_fire & lane0 & hit_msk) begin
			msk_q <= I_WB_DAT[EOC_IRQ_W-1:0];
		end
	end

	always_ff @(posedge I_CLOCK) begin
		if (I_SYS_RST) begin
			irq_q <= 1'b0;
		end else begin
			irq_q <= |(sts_q & msk_q);
		end
	end

	// decoded drive-circuit controls and pin ownership
	always_ff @(posedge I_CLOCK) begin
		if (I_SYS_RST) begin
			en_q      <= 1'b0;
			cmos_q    <= 1'b0;
			rc_q      <= 1'b0;
			cap_q     <= 1'b0;
			xtal_q    <= 1'b0;
			half_q    <= 1'b0;
			pin_in_q  <= 1'b0;
			pin_out_q <= 1'b0;
		end else begin
			en_q      <= osc_on;
			cmos_q    <= (mode_q == EOC_MODE_CMOS) |
				(mode_q == EOC_MODE_CMOS_DIV2);
			rc_q      <= (mode_q == EOC_MODE_RC);
			cap_q     <= (mode_q == EOC_MODE_CAP);
			xtal_q    <= (mode_q == EOC_MODE_XTAL) |
				(mode_q == EOC_MODE_XTAL_DIV2);
			half_q    <= (mode_q == EOC_MODE_CMOS_DIV2) |
				(mode_q == EOC_MODE_XTAL_DIV2);
			pin_in_q  <= xtal_mode;
			pin_out_q <= osc_on;
		end
	end

	assign O_WB_ACK             = ack_q;
	assign O_WB_DAT             = rd_q;
	assign O_FINE_TRIM          = trim_q;
	assign O_EXT_OSC_MODE_SEL   = mode_q;
	assign O_EXT_OSC_FREQ_CTRL  = freq_q;
	assign O_OSC_ENABLE         = en_q;
	assign O_OSC_CMOS           = cmos_q;
	assign O_OSC_RC             = rc_q;
	assign O_OSC_CAP            = cap_q;
	assign O_OSC_XTAL           = xtal_q;
	assign O_OSC_HALF           = half_q;
	assign O_OSC_IN_PIN_CLAIM   = pin_in_q;
	assign O_OSC_OUT_PIN_CLAIM  = pin_out_q;
	assign O_CRYSTAL_VALID_FLAG = valid_q;
	assign O_SYSCLK_SOURCE_SEL  = sel_q;
	assign O_EXT_DIV8_TICK      = tick_q;
	assign O_IRQ                = irq_q;

endmodule // eoc_ext_osc_ctrl

`default_nettype wire

// >>> sim/eoc_osc_model.sv
// behavioural external oscillator: clock source and amplitude detector
`timescale 1ns/10ps
`default_nettype none
module eoc_osc_model #(
	parameter int HALF_NS   = 21,
	parameter int SETTLE_NS = 2000
) (
	input  wire logic i_run,
	input  wire logic i_xtal,
	output var  logic o_clk,
	output var  logic o_amp_ok
);
	// slower than the system clock and unrelated in phase
	initial o_clk = 1'h0;
	always begin
		#(HALF_NS);
		o_clk = i_run ? ~o_clk : 1'h0;
	end
	// settle time far shorter than a real crystal, to keep runs short
	always begin
		o_amp_ok = 1'h0;
		wait (i_xtal);
		#(SETTLE_NS);
		o_amp_ok = i_xtal;
		wait (!i_xtal);
	end
endmodule // eoc_osc_model
`default_nettype wire

// >>> sim/eoc_ext_osc_ctrl_props.sv
// assertions for the external oscillator control block
`timescale 1ns/10ps
`default_nettype none
module eoc_ext_osc_ctrl_chk (
	input wire logic                           I_CLOCK,
	input wire logic                           I_SYS_RST,
	input wire logic [11:0]                    I_WB_ADR,
	input wire logic [eoc_pkg::EOC_TRIM_W-1:0] I_FACTORY_TRIM,
	input wire logic [31:0]                    O_WB_DAT,
	input wire logic                           O_WB_ACK,
	input wire logic [eoc_pkg::EOC_TRIM_W-1:0] O_FINE_TRIM,
	input wire logic [2:0]                     O_EXT_OSC_MODE_SEL,
	input wire logic                           O_OSC_ENABLE,
	input wire logic                           O_OSC_HALF,
	input wire logic                           O_OSC_IN_PIN_CLAIM,
	input wire logic                           O_CRYSTAL_VALID_FLAG,
	input wire logic                           O_SYSCLK_SOURCE_SEL,
	input wire logic                           O_EXT_DIV8_TICK
);
	import eoc_pkg::*;
	default clocking cb @(posedge I_CLOCK); endclocking
	default disable iff (I_SYS_RST);
	wire logic [9:0] idx = I_WB_ADR[11:2];
	property p_trim_hi;
		O_WB_ACK && idx == EOC_IDX_FINE_TRIM |-> O_WB_DAT[7:6] == 2'h0;
	endproperty
	a_trim_hi: assert property (p_trim_hi) else $error("trim top bits");
	property p_trim_rst;
		$fell(I_SYS_RST) |-> O_FINE_TRIM == $past(I_FACTORY_TRIM);
	endproperty
	a_trim_rst: assert property (p_trim_rst) else $error("trim reset");
	property p_rsvd;
		O_WB_ACK && idx == EOC_IDX_EXT_OSC |-> !O_WB_DAT[3];
	endproperty
	a_rsvd: assert property (p_rsvd) else $error("reserved bit set");
	property p_vld;
		O_CRYSTAL_VALID_FLAG |-> $past(O_EXT_OSC_MODE_SEL[2:1]) == 2'h3;
	endproperty
	a_vld: assert property (p_vld) else $error("valid off crystal");
	property p_claim;
		O_OSC_IN_PIN_CLAIM == ($past(O_EXT_OSC_MODE_SEL[2:1]) == 2'h3);
	endproperty
	a_claim: assert property (p_claim) else $error("input pin claim");
	property p_half;
		O_OSC_HALF == ($past(O_EXT_OSC_MODE_SEL[1:0]) == 2'h3);
	endproperty
	a_half: assert property (p_half) else $error("half decode");
	// eight synchronised edges need at least sixteen system cycles
	property p_tick;
		O_EXT_DIV8_TICK |=> (!O_EXT_DIV8_TICK) [*8];
	endproperty
	a_tick: assert property (p_tick) else $error("tick too close");
	property p_sel;
		$rose(O_SYSCLK_SOURCE_SEL) |-> O_OSC_ENABLE;
	endproperty
	a_sel: assert property (p_sel) else $error("select while off");
	c_tick: cover property (O_EXT_DIV8_TICK);
	c_vld: cover property ($rose(O_CRYSTAL_VALID_FLAG));
	c_sel: cover property ($rose(O_SYSCLK_SOURCE_SEL));
endmodule // eoc_ext_osc_ctrl_chk
bind eoc_ext_osc_ctrl eoc_ext_osc_ctrl_chk u_chk (
	.I_CLOCK(I_CLOCK), .I_SYS_RST(I_SYS_RST), .I_WB_ADR(I_WB_ADR),
	.I_FACTORY_TRIM(I_FACTORY_TRIM), .O_WB_DAT(O_WB_DAT),
	.O_WB_ACK(O_WB_ACK), .O_FINE_TRIM(O_FINE_TRIM),
	.O_EXT_OSC_MODE_SEL(O_EXT_OSC_MODE_SEL), .O_OSC_ENABLE(O_OSC_ENABLE),
	.O_OSC_HALF(O_OSC_HALF), .O_OSC_IN_PIN_CLAIM(O_OSC_IN_PIN_CLAIM),
	.O_CRYSTAL_VALID_FLAG(O_CRYSTAL_VALID_FLAG),
	.O_SYSCLK_SOURCE_SEL(O_SYSCLK_SOURCE_SEL),
	.O_EXT_DIV8_TICK(O_EXT_DIV8_TICK));
`default_nettype wire

// >>> sim/tb_top.sv
// self-checking bench for the external oscillator control block
`timescale 1ns/10ps
`default_nettype none
module tb_top;
	import eoc_pkg::*;
	logic                  clk = 1'h0;
	logic                  rst = 1'h1;
	logic                  cyc = 1'h0;
	logic                  stb = 1'h0;
	logic                  we = 1'h0;
	logic [11:0]           adr = 12'h000;
	logic [31:0]           wd = 32'h0;
	logic [3:0]            sel = 4'h0;
	logic [EOC_TRIM_W-1:0] fac = 6'h15; // calibration value, arbitrary
	logic [31:0]           q;
	wire logic [31:0]      rd;
	wire logic [7:0]       dec;
	wire logic [5:0]       tr;
	wire logic [2:0]       ms, fc;
	wire logic             ack, ext, amp, vf, ss, tick, irq;
	int                    failures = 0;
	int                    cmp_count = 0;
	int                    nt = 0;
	int                    ne = 0;
	logic                  win = 1'h0;
	always #4 clk = ~clk;
	eoc_ext_osc_ctrl dut (
		.I_CLOCK(clk), .I_SYS_RST(rst), .I_WB_CYC(cyc), .I_WB_STB(stb),
		.I_WB_WE(we), .I_WB_ADR(adr), .I_WB_DAT(wd), .I_WB_SEL(sel),
		.O_WB_DAT(rd), .O_WB_ACK(ack), .I_FACTORY_TRIM(fac),
		.I_EXT_OSC_CLK(ext), .I_XTAL_AMP_OK(amp), .O_FINE_TRIM(tr),
		.O_EXT_OSC_MODE_SEL(ms), .O_EXT_OSC_FREQ_CTRL(fc),
		.O_OSC_ENABLE(dec[7]), .O_OSC_CMOS(dec[6]), .O_OSC_RC(dec[5]),
		.O_OSC_CAP(dec[4]), .O_OSC_XTAL(dec[3]), .O_OSC_HALF(dec[2]),
		.O_OSC_IN_PIN_CLAIM(dec[1]), .O_OSC_OUT_PIN_CLAIM(dec[0]),
		.O_CRYSTAL_VALID_FLAG(vf), .O_SYSCLK_SOURCE_SEL(ss),
		.O_EXT_DIV8_TICK(tick), .O_IRQ(irq));
	eoc_osc_model osc (.i_run(dec[7]), .i_xtal(dec[3]), .o_clk(ext),
		.o_amp_ok(amp));
	always @(posedge clk)
		if (win) nt <= nt + int'(tick);
	always @(posedge ext)
		if (win) ne++;
	task automatic chk(input string nm, input logic [31:0] s, e);
		cmp_count++;
		if (s !== e) begin
			failures++;
			$display("mismatch %s expected %h seen %h", nm, e, s);
		end
	endtask
	// one classic cycle; caller enters just after a rising edge
	task automatic bus(input logic [9:0] i, input logic w, input logic [7:0] d);
		int n;
		n = 0;
		cyc <= 1'h1;
		stb <= 1'h1;
		we <= w;
		adr <= {i, 2'h0};
		wd <= {24'h0, d};
		sel <= 4'hF;
		do begin
			@(posedge clk);
			n++;
		end while (ack !== 1'h1 && n < 40);
		q = rd;
		cyc <= 1'h0;
		stb <= 1'h0;
		if (n >= 40) failures++;
		@(posedge clk);
	endtask
	task automatic rchk(input string nm, input logic [9:0] i, input logic [7:0] e);
		bus(i, 1'h0, 8'h00);
		chk(nm, q, {24'h0, e});
	endtask
	function automatic logic [7:0] exp_dec(input logic [2:0] m);
		return {m[2:1] != 2'h0, m[2:1] == 2'h1, m == EOC_MODE_RC,
			m == EOC_MODE_CAP, m[2:1] == 2'h3, m[1] && m[0],
			m[2:1] == 2'h3, m[2:1] != 2'h0};
	endfunction
	task automatic tally_and_finish();
		$display("compares %0d mismatches %0d", cmp_count, failures);
		if (failures == 0 && cmp_count > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	initial begin
		#100000;
		failures++;
		tally_and_finish();
	end
	initial begin
		int d;
		logic [2:0] m;
		repeat (5) @(posedge clk);
		rst <= 1'h0;
		@(posedge clk);
		rchk("trim", EOC_IDX_FINE_TRIM, {2'h0, fac});
		rchk("ctrl", EOC_IDX_EXT_OSC, 8'h00);
		bus(EOC_IDX_CLK_SEL, 1'h1, 8'h01);
		rchk("clksel", EOC_IDX_CLK_SEL, 8'h00);
		bus(EOC_IDX_FINE_TRIM, 1'h1, 8'hFF);
		rchk("trim", EOC_IDX_FINE_TRIM, 8'h3F);
		rchk("status", EOC_IDX_IRQ_STATUS, 8'h0C);
		bus(EOC_IDX_IRQ_STATUS, 1'h1, 8'h0C);
		bus(EOC_IDX_FINE_TRIM, 1'h1, {2'h0, EOC_TRIM_MAX});
		rchk("trim", EOC_IDX_FINE_TRIM, {2'h0, EOC_TRIM_MAX});
		rchk("status", EOC_IDX_IRQ_STATUS, 8'h00);
		rchk("unmapped", 10'h0B2, 8'h00);
		// reserved bit written as one on purpose, must read back zero
		for (int k = 0; k < 8; k++) begin
			m = k[2:0];
			bus(EOC_IDX_EXT_OSC, 1'h1, {1'h0, m, 1'h1, m});
			rchk("ctrl", EOC_IDX_EXT_OSC, {1'h0, m, 1'h0, m});
			chk("decode", {24'h0, dec}, {24'h0, exp_dec(m)});
			chk("freq", {29'h0, fc}, {29'h0, m});
		end
		for (int k = 2; k < 4; k++) begin
			d = 8 << (k - 2);
			bus(EOC_IDX_EXT_OSC, 1'h1, {1'h0, k[2:0], 4'h0});
			repeat (20) @(posedge clk);
			nt = 0;
			ne = 0;
			win <= 1'h1;
			repeat (1000) @(posedge clk);
			win <= 1'h0;
			@(posedge clk);
			chk("ticks", {31'h0, nt > 0 && ne <= nt * d + d && ne + d >= nt * d},
				32'h1);
		end
		bus(EOC_IDX_EXT_OSC, 1'h1, 8'h67);
		rchk("ctrl", EOC_IDX_EXT_OSC, 8'h67);
		repeat (300) @(posedge clk);
		repeat (20)
			if (q[7] !== 1'h1) bus(EOC_IDX_EXT_OSC, 1'h0, 8'h00);
		chk("ctrl", q, 32'hE7);
		chk("irq", {31'h0, irq}, 32'h0);
		bus(EOC_IDX_IRQ_MASK, 1'h1, 8'h01);
		rchk("status", EOC_IDX_IRQ_STATUS, 8'h01);
		chk("irq", {31'h0, irq}, 32'h1);
		bus(EOC_IDX_CLK_SEL, 1'h1, 8'h01);
		rchk("clksel", EOC_IDX_CLK_SEL, 8'h01);
		chk("sysclk", {31'h0, ss}, 32'h1);
		bus(EOC_IDX_IRQ_STATUS, 1'h1, 8'h01);
		rchk("status", EOC_IDX_IRQ_STATUS, 8'h00);
		chk("irq", {31'h0, irq}, 32'h0);
		bus(EOC_IDX_EXT_OSC, 1'h1, 8'h47);
		rchk("ctrl", EOC_IDX_EXT_OSC, 8'h47);
		tally_and_finish();
	end
endmodule // tb_top
`default_nettype wire
